// ==== ramp_status_flags_tb.sv ====
// Self-checking bench for the motion ramp status word
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module ramp_status_flags_tb;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, softstop_enable = 1'b0;
	logic ref_r_pin = 1'b0, ref_l_pin = 1'b0, pol_stop_r = 1'b0;
	logic pol_stop_l = 1'b0, stop_r_enable = 1'b0, stop_l_enable = 1'b0;
	logic vstop_r_enable = 1'b0, vstop_l_enable = 1'b0;
	logic halt_on_stall_enable = 1'b0, virt_stop_r = 1'b1, virt_stop_l = 1'b1;
	logic stall_load_det = 1'b0, stall_cstep = 1'b0, cstep_enable = 1'b0;
	logic reversal_evt = 1'b0, latch_r_evt = 1'b0, latch_l_evt = 1'b0;
	rsf_pkg::rsf_ramp_mode_t ramp_mode = rsf_pkg::RSF_MODE_POSITION;
	logic [31:0] current_position = 32'h0000_0001, goal_position = 32'h0;
	logic signed [31:0] current_velocity = 32'sh5;
	logic [31:0] velocity_ceiling = 32'h0000_0007;
	logic [15:0] standstill_wait_time = 16'h0006;
	logic [6:0]  reg_addr;
	logic        reg_wr, reg_rd, irq, stall_halt_event;
	logic        stop_r_req, stop_l_req, standstill_hold;
	logic [31:0] reg_wdata, reg_rdata, d, seed_v;
	int          fail_count = 0, cmp_count = 0, n;
	// Free-running 50 MHz clock
	always #10 clk = ~clk;
	rsf_status rsf_status_i (.clk, .rstn, .ce, .ref_r_pin, .ref_l_pin,
		.pol_stop_r, .pol_stop_l, .stop_r_enable, .stop_l_enable,
		.vstop_r_enable, .vstop_l_enable, .softstop_enable,
		.halt_on_stall_enable, .virt_stop_r, .virt_stop_l, .stall_load_det,
		.stall_cstep, .cstep_enable, .reversal_evt, .latch_r_evt,
		.latch_l_evt, .ramp_mode, .current_position, .goal_position,
		.current_velocity, .velocity_ceiling, .standstill_wait_time,
		.reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .irq,
		.stall_halt_event, .stop_r_req, .stop_l_req, .standstill_hold);
	rsf_host_model rsf_host_model_i (.clk, .reg_rdata, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd);
	// Short helpers for waits and status word access
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick
	task automatic rdw(output logic [31:0] v);
		rsf_host_model_i.rd(7'h2B, v);
	endtask : rdw
	task automatic wrw(input logic [31:0] v);
		rsf_host_model_i.wr(7'h2B, v);
	endtask : wrw
	// Verdict and end of run
	task automatic close_out();
		$display("Counts: %0d compared, %0d mismatched", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	// Hang guard, far beyond the expected run
	initial begin
		#80000;
		fail_count++;
		close_out();
	end
	// Main sequence
	initial begin
		seed_v = $urandom(32'h13A57D76);
		tick(3);
		#1 `CHK(reg_rdata, 32'h0)
		`CHK(irq, 1'b0)
		@(posedge clk);
		rstn <= 1'b1;
		rdw(d);
		`CHK(d, 32'h0000_C000)
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			{virt_stop_r, virt_stop_l, stall_load_det, stall_cstep,
				cstep_enable} <= 5'($urandom);
			tick(2);
			rdw(d);
			`CHK(d[15:14], {virt_stop_r, virt_stop_l})
			`CHK(d[13], stall_load_det | (stall_cstep & cstep_enable))
			`CHK(d[31:16], 16'h0000)
		end
		@(posedge clk);
		{stall_load_det, stall_cstep} <= 2'b00;
		current_position <= $urandom;
		goal_position <= 32'h0;
		tick(2);
		goal_position <= current_position;
		tick(3);
		rdw(d);
		`CHK(d[9:7], 3'b101)
		`CHK(irq, 1'b1)
		wrw(32'h0000_0000);
		rdw(d);
		`CHK(d[7], 1'b1)
		wrw(32'h0000_0080);
		rdw(d);
		`CHK(d[9:7], 3'b100)
		`CHK(irq, 1'b0)
		@(posedge clk);
		goal_position <= current_position + 32'h1;
		tick(2);
		rdw(d);
		`CHK(d[9], 1'b0)
		$display("test position done");
		@(posedge clk);
		velocity_ceiling <= {1'b0, 31'($urandom)};
		@(posedge clk);
		current_velocity <= velocity_ceiling;
		tick(2);
		rdw(d);
		`CHK(d[10:8], 3'b001)
		@(posedge clk);
		current_velocity <= 32'sh0;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			#1 if (standstill_hold === 1'b1) n++;
		end
		`CHK(n, 6)
		rdw(d);
		`CHK(d[11:10], 2'b01)
		$display("test velocity done");
		@(posedge clk);
		halt_on_stall_enable <= 1'b1;
		stall_load_det <= 1'b1;
		@(posedge clk);
		stall_load_det <= 1'b0;
		tick(2);
		rdw(d);
		`CHK({d[6], stall_halt_event, irq}, 3'b111)
		wrw(32'h0000_0040);
		rdw(d);
		`CHK({d[6], stall_halt_event, irq}, 3'b000)
		$display("test stall done");
		@(posedge clk);
		{reversal_evt, latch_r_evt, latch_l_evt} <= 3'b111;
		@(posedge clk);
		{reversal_evt, latch_r_evt, latch_l_evt} <= 3'b000;
		tick(2);
		rsf_host_model_i.wr(7'h2C, 32'hFFFF_FFFF);
		rsf_host_model_i.rd(7'h2C, d);
		`CHK(d, 32'h0)
		rdw(d);
		`CHK(d & 32'hFFFF_100C, 32'h0000_100C)
		wrw(32'h0000_0008);
		rdw(d);
		`CHK(d & 32'h100C, 32'h1004)
		wrw(32'h0000_1004);
		rdw(d);
		`CHK(d & 32'h100C, 32'h0)
		$display("test sticky done");
		@(posedge clk);
		current_velocity <= 32'sh5;
		stop_r_enable <= 1'b1;
		ref_r_pin <= 1'b1;
		tick(5);
		rdw(d);
		`CHK({d[5], d[1], stop_r_req, irq}, 4'b1111)
		@(posedge clk);
		ramp_mode <= rsf_pkg::RSF_MODE_HOLD;
		tick(2);
		rdw(d);
		`CHK({d[5], stop_r_req}, 2'b00)
		@(posedge clk);
		{pol_stop_l, ref_l_pin, stop_l_enable} <= 3'b101;
		current_velocity <= -32'sh5;
		ramp_mode <= rsf_pkg::RSF_MODE_VEL_NEG;
		tick(5);
		rdw(d);
		`CHK({d[4], d[0], stop_l_req}, 3'b111)
		@(posedge clk);
		stop_l_enable <= 1'b0;
		tick(2);
		rdw(d);
		`CHK({d[4], stop_l_req}, 2'b00)
		// Clock enable low freezes the stop flag
		@(posedge clk);
		ce <= 1'b0;
		stop_l_enable <= 1'b1;
		tick(3);
		#1 `CHK(stop_l_req, 1'b0)
		@(posedge clk);
		ce <= 1'b1;
		tick(2);
		#1 `CHK(stop_l_req, 1'b1)
		$display("test stop done");
		close_out();
	end
endmodule : ramp_status_flags_tb

// ==== rsf_cfg.svh ====
// Offsets, bit positions and reset values of the motion ramp status word
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
`define RSF_ADDR_W        7
`define RSF_STAT_ADDR     7'h2B
`define RSF_STAT_RESET    16'hC000
`define RSF_BIT_VSTOP_R   15
`define RSF_BIT_VSTOP_L   14
`define RSF_BIT_STALL     13
`define RSF_BIT_SECOND    12
`define RSF_BIT_ZWAIT     11
`define RSF_BIT_VZERO     10
`define RSF_BIT_POS_RCH   9
`define RSF_BIT_VEL_RCH   8
`define RSF_BIT_EV_POS    7
`define RSF_BIT_EV_STALL  6
`define RSF_BIT_EV_STOP_R 5
`define RSF_BIT_EV_STOP_L 4
`define RSF_BIT_LATCH_R   3
`define RSF_BIT_LATCH_L   2
`define RSF_BIT_REF_R     1
`define RSF_BIT_REF_L     0
`define RSF_STICKY_N      5
`define RSF_STICKY_RESET  5'h00
`define RSF_SYNC_RESET    2'h0
`endif

// ==== rsf_flag_if.sv ====
// Set, clear and flag lines between the status block and its sticky bank
`timescale 1ns/1ns
interface rsf_flag_if #(parameter int N = 5);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	modport keeper (input set, input clr, output flags);
	modport user   (output set, output clr, input flags);
endinterface : rsf_flag_if

// ==== rsf_host_model.sv ====
// Host-side register access model for the motion ramp status word
`timescale 1ns/1ns
module rsf_host_model (
	input  wire logic        clk,       // System clock
	input  wire logic [31:0] reg_rdata, // Read answer
	output logic [6:0]       reg_addr,  // Register address
	output logic             reg_wr,    // Write strobe
	output logic [31:0]      reg_wdata, // Write data
	output logic             reg_rd     // Read strobe
);
	// Idle bus at time zero
	initial begin
		reg_addr  = 7'h00;
		reg_wr    = 1'b0;
		reg_wdata = 32'h0000_0000;
		reg_rd    = 1'b0;
	end
	// Strobe one cycle, take the answer once the read edge has landed
	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a; // Released address shows a changed value
		#1 d = reg_rdata;
	endtask : rd
	// Strobe one cycle, then scramble the released data lines
	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~v;
	endtask : wr
endmodule : rsf_host_model

// ==== rsf_pkg.sv ====
// Types shared by the motion ramp status block
package rsf_pkg;
	typedef logic [15:0] rsf_word_t;
	typedef enum logic [1:0] {
		RSF_MODE_POSITION = 2'h0,
		RSF_MODE_VEL_POS  = 2'h1,
		RSF_MODE_VEL_NEG  = 2'h2,
		RSF_MODE_HOLD     = 2'h3
	} rsf_ramp_mode_t;
endpackage : rsf_pkg

// ==== rsf_status.sv ====
// Motion ramp status word: live levels, sticky events and readback
// Function
// - Bit 15 shows the right virtual stop state, reset value one.
// - Bit 14 shows the left virtual stop state, reset value one.
// - Bit 13 is live stall from load detect or enabled constant-step unit.
// - Bit 12 sticks on a reversed automatic move; write one clears.
// - Bit 11 is high during the standstill wait after a stop.
// - Bit 10 is high while velocity is zero.
// - Bit 9 is high while position equals goal position.
// - Bit 8 is high while velocity equals the velocity ceiling.
// - Bit 7 sticks on position reached, write one clears, feeds interrupt.
// - Bit 6 latches a stall halt, feeds interrupt; clearing releases motion.
// - Bits 5 and 4 show stop conditions, feed interrupt, clear as specified.
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_status #(
	parameter int POS_W  = 32,  // Position width
	parameter int VEL_W  = 32,  // Velocity width
	parameter int WAIT_W = 16   // Standstill wait count width
) (
	input  wire logic                   clk,              // 50 MHz clock
	input  wire logic                   rstn,             // Sync reset
	input  wire logic                   ce,               // Clock enable
	input  wire logic                   ref_r_pin,        // Right switch pin
	input  wire logic                   ref_l_pin,        // Left switch pin
	input  wire logic                   pol_stop_r,       // Right inverted
	input  wire logic                   pol_stop_l,       // Left inverted
	input  wire logic                   stop_r_enable,    // Right stop on
	input  wire logic                   stop_l_enable,    // Left stop on
	input  wire logic                   vstop_r_enable,   // Virt right on
	input  wire logic                   vstop_l_enable,   // Virt left on
	input  wire logic                   softstop_enable,  // Soft stop mode
	input  wire logic                   halt_on_stall_enable, // Stall halt
	input  wire logic                   virt_stop_r,      // Virt right cond
	input  wire logic                   virt_stop_l,      // Virt left cond
	input  wire logic                   stall_load_det,   // Regulator stall
	input  wire logic                   stall_cstep,      // Const-step stall
	input  wire logic                   cstep_enable,     // Const-step on
	input  wire logic                   reversal_evt,     // Move reversed
	input  wire logic                   latch_r_evt,      // Right latch done
	input  wire logic                   latch_l_evt,      // Left latch done
	input  rsf_pkg::rsf_ramp_mode_t     ramp_mode,        // Ramp mode
	input  wire logic [POS_W-1:0]       current_position, // Position
	input  wire logic [POS_W-1:0]       goal_position,    // Target
	input  wire logic signed [VEL_W-1:0] current_velocity, // Velocity
	input  wire logic [VEL_W-1:0]       velocity_ceiling, // Max velocity
	input  wire logic [WAIT_W-1:0]      standstill_wait_time, // Wait cycles
	input  wire logic [`RSF_ADDR_W-1:0] reg_addr,         // Register address
	input  wire logic                   reg_wr,           // Write strobe
	input  wire logic [31:0]            reg_wdata,        // Write data
	input  wire logic                   reg_rd,           // Read strobe
	output logic [31:0]                 reg_rdata,        // Read data
	output logic                        irq,              // Interrupt
	output logic                        stall_halt_event, // Stall halt held
	output logic                        stop_r_req,       // Right stop
	output logic                        stop_l_req,       // Left stop
	output logic                        standstill_hold   // Wait in progress
);
	rsf_flag_if #(.N(`RSF_STICKY_N)) fl ();

	rsf_sticky #(.N(`RSF_STICKY_N)) u_sticky (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.fl   (fl.keeper)
	);

	// Equality of two words, used for position and velocity
	function automatic logic is_match(input logic [63:0] a,
	                                  input logic [63:0] b);
		is_match = (a == b);
	endfunction : is_match

	logic [1:0]          sync_r;
	logic [1:0]          sync_l;
	rsf_pkg::rsf_word_t  live;
	logic [WAIT_W-1:0]   wait_cnt;
	logic [31:0]         rdata;
	logic                irq_q;
	logic [1:0]          next_sync_r;
	logic [1:0]          next_sync_l;
	rsf_pkg::rsf_word_t  next_live;
	logic [WAIT_W-1:0]   next_wait_cnt;
	logic [31:0]         next_rdata;
	logic                next_irq;
	rsf_pkg::rsf_word_t  word;
	logic                ref_r_act;
	logic                ref_l_act;
	logic                cond_r;
	logic                cond_l;
	logic                vzero_now;
	logic                pos_now;
	logic                vel_neg;
	logic                vel_pos;
	logic                stall_now;
	logic                hit;
	logic                clear_r;
	logic                clear_l;

	// Status word: live flops plus sticky flags
	always_comb begin
		word = live;
		word[`RSF_BIT_SECOND]   = fl.flags[4];
		word[`RSF_BIT_EV_POS]   = fl.flags[3];
		word[`RSF_BIT_EV_STALL] = fl.flags[2];
		word[`RSF_BIT_LATCH_R]  = fl.flags[1];
		word[`RSF_BIT_LATCH_L]  = fl.flags[0];
	end

	// Switch levels after sync and polarity, stop conditions, compares
	always_comb begin
		ref_r_act = sync_r[1] ^ pol_stop_r;
		ref_l_act = sync_l[1] ^ pol_stop_l;
		cond_r    = (ref_r_act & stop_r_enable)
		          | (virt_stop_r & vstop_r_enable);
		cond_l    = (ref_l_act & stop_l_enable)
		          | (virt_stop_l & vstop_l_enable);
		vzero_now = (current_velocity == '0);
		vel_neg   = current_velocity[VEL_W-1];
		vel_pos   = !vel_neg && !vzero_now;
		pos_now   = is_match(64'(current_position),
		                     64'(goal_position));
		stall_now = stall_load_det | (cstep_enable & stall_cstep);
		hit       = (reg_addr == `RSF_STAT_ADDR);
		// Hold, opposite move, soft stop done, or disable drops the stop
		clear_r   = (ramp_mode == rsf_pkg::RSF_MODE_HOLD) || vel_neg
		          || (softstop_enable && vzero_now) || !cond_r;
		clear_l   = (ramp_mode == rsf_pkg::RSF_MODE_HOLD) || vel_pos
		          || (softstop_enable && vzero_now) || !cond_l;
	end

	// Sticky sources and write-one-to-clear strobes
	always_comb begin
		fl.set[4] = reversal_evt;
		fl.set[3] = pos_now & ~live[`RSF_BIT_POS_RCH];
		fl.set[2] = halt_on_stall_enable & stall_now;
		fl.set[1] = latch_r_evt;
		fl.set[0] = latch_l_evt;
		// Zero bits of the write leave their flags alone
		fl.clr = {`RSF_STICKY_N{reg_wr & hit}} & {
			reg_wdata[`RSF_BIT_SECOND], reg_wdata[`RSF_BIT_EV_POS],
			reg_wdata[`RSF_BIT_EV_STALL], reg_wdata[`RSF_BIT_LATCH_R],
			reg_wdata[`RSF_BIT_LATCH_L]};
	end

	// Next values of live bits, wait counter, readback and interrupt
	always_comb begin
		next_sync_r = {sync_r[0], ref_r_pin};
		next_sync_l = {sync_l[0], ref_l_pin};
		next_wait_cnt = wait_cnt;
		// A new standstill starts the wait
		if (vzero_now && !live[`RSF_BIT_VZERO])
			next_wait_cnt = standstill_wait_time;
		else if (wait_cnt != '0)
			next_wait_cnt = wait_cnt - WAIT_W'(1);
		next_live = '0;
		next_live[`RSF_BIT_VSTOP_R] = virt_stop_r;
		next_live[`RSF_BIT_VSTOP_L] = virt_stop_l;
		next_live[`RSF_BIT_STALL]   = stall_now;
		next_live[`RSF_BIT_ZWAIT]   = (next_wait_cnt != '0);
		next_live[`RSF_BIT_VZERO]   = vzero_now;
		next_live[`RSF_BIT_POS_RCH] = pos_now;
		// Raw bit compare: no sign extension of the velocity
		next_live[`RSF_BIT_VEL_RCH] = is_match(
			64'($unsigned(current_velocity)),
			64'(velocity_ceiling));
		next_live[`RSF_BIT_EV_STOP_R] = !clear_r
			&& (live[`RSF_BIT_EV_STOP_R] || vel_pos);
		next_live[`RSF_BIT_EV_STOP_L] = !clear_l
			&& (live[`RSF_BIT_EV_STOP_L] || vel_neg);
		next_live[`RSF_BIT_REF_R] = ref_r_act;
		next_live[`RSF_BIT_REF_L] = ref_l_act;
		next_rdata = rdata;
		if (reg_rd)
			next_rdata = hit ? {16'h0000, word} : 32'h0000_0000;
		next_irq = word[`RSF_BIT_EV_POS] | word[`RSF_BIT_EV_STALL]
		         | word[`RSF_BIT_EV_STOP_R]
		         | word[`RSF_BIT_EV_STOP_L];
	end

	// Register all state, frozen while the clock enable is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync_r   <= `RSF_SYNC_RESET;
			sync_l   <= `RSF_SYNC_RESET;
			live     <= `RSF_STAT_RESET;
			wait_cnt <= '0;
			rdata    <= 32'h0000_0000;
			irq_q    <= 1'b0;
		end else if (ce) begin
			sync_r   <= next_sync_r;
			sync_l   <= next_sync_l;
			live     <= next_live;
			wait_cnt <= next_wait_cnt;
			rdata    <= next_rdata;
			irq_q    <= next_irq;
		end
	end

	// Outputs straight from flops
	assign reg_rdata        = rdata;
	assign irq              = irq_q;
	assign stall_halt_event = fl.flags[2];
	assign stop_r_req       = live[`RSF_BIT_EV_STOP_R];
	assign stop_l_req       = live[`RSF_BIT_EV_STOP_L];
	assign standstill_hold  = live[`RSF_BIT_ZWAIT];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_VSTOP_R: assert property (ce |=> word[15] == $past(virt_stop_r))
		else $error("Right virtual stop bit wrong");
	AST_VSTOP_L: assert property (ce |=> word[14] == $past(virt_stop_l))
		else $error("Left virtual stop bit wrong");
	AST_STALL: assert property (ce |=> word[13] == $past(stall_now))
		else $error("Live stall bit wrong");
	AST_SECOND: assert property (ce && reversal_evt |=> word[12])
		else $error("Reversal flag not set");
	AST_ZWAIT: assert property (ce && vzero_now && !live[10]
		&& standstill_wait_time > 1 |=> word[11] && word[10])
		else $error("Standstill wait not shown");
	AST_VZERO: assert property (ce |=> word[10] == $past(vzero_now))
		else $error("Zero velocity bit wrong");
	AST_POS: assert property (ce |=> word[9] == $past(pos_now))
		else $error("Position reached bit wrong");
	AST_EVPOS: assert property (ce && pos_now && !word[9]
		|=> word[7])
		else $error("Position event not set");
	AST_IRQ: assert property (ce && word[7:4] != 4'h0 |=> irq)
		else $error("Interrupt missing for an event");
	AST_HALT: assert property (ce && halt_on_stall_enable && stall_now
		|=> stall_halt_event)
		else $error("Stall halt not latched");
	AST_HOLD: assert property (ce && ramp_mode == rsf_pkg::RSF_MODE_HOLD
		|=> !word[5] && !word[4])
		else $error("Stop flags not cleared by hold");
	AST_UPPER: assert property (reg_rdata[31:16] == 16'h0000)
		else $error("Upper bits not zero");
	AST_ZERO_WR: assert property (ce && reg_wr && hit && word[7]
		&& !reg_wdata[7] |=> word[7])
		else $error("Zero write cleared a flag");

	COV_POS: cover property (ce && fl.set[3] ##1 ce && fl.clr[3]);
	COV_STOP_R: cover property (ce && !word[5] ##1 word[5]);
	COV_WAIT: cover property (word[11] ##1 !word[11]);
	COV_READ: cover property (ce && reg_rd && hit);
endmodule : rsf_status

// ==== rsf_sticky.sv ====
// Bank of sticky flags, write-one-to-clear, set beats clear
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_sticky #(parameter int N = `RSF_STICKY_N) (
	input  wire logic  clk,   // System clock
	input  wire logic  rstn,  // Synchronous reset, active low
	input  wire logic  ce,    // Clock enable
	rsf_flag_if.keeper fl     // Set, clear and flag lines
);
	logic [N-1:0] flags;
	logic [N-1:0] next_flags;

	// Set wins over a clear in the same cycle
	always_comb begin
		next_flags = (flags & ~fl.clr) | fl.set;
	end

	// Register flags
	always_ff @(posedge clk) begin
		if (!rstn)
			flags <= N'(`RSF_STICKY_RESET);
		else if (ce)
			flags <= next_flags;
	end

	assign fl.flags = flags;
endmodule : rsf_sticky
